//--- hw/pcs_lane_align_status.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pcs_lane_align_status import pcs_align_pkg::*; #(
	parameter int NUM = NUM_LANES,
	parameter int IDW = LANE_IDW,
	parameter int MF_CYCLES = MF_CYCLES_DEF
) (
	input wire logic clk_i, // receive clock
	input wire logic sys_rst_i, // sync reset, high
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb access phase
	input wire logic pwrite_i, // apb write
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb unmapped address
	input wire logic [NUM-1:0] word_boundary_locked_flags_i, // per physical lane
	input wire logic [NUM-1:0] marker_valid_i, // marker word per physical lane
	input wire logic [NUM-1:0] marker_bad_i, // marker malformed
	input wire logic [NUM*IDW-1:0] marker_id_i, // decoded pcs lane ids
	input wire logic remote_fault_det_i, // remote fault condition
	output logic lane_misalign_pulse_o, // alignment error pulse
	output logic remote_fault_o, // remote fault level
	output logic [NUM-1:0][IDW-1:0] pcs_lane_phys_map_o, // per pcs lane
	output logic [NUM-1:0] pcs_lane_synced_flags_o, // per pcs lane
	output logic [NUM-1:0] lane_marker_word_error_o, // per physical lane
	output logic irq_o // level interrupt
);
	localparam logic [MF_TMR_W-1:0] MF_LAST = MF_TMR_W'(MF_CYCLES - 1);
	localparam logic [PEND_W-1:0] PEND_MAX = '1;

	typedef struct packed {
		logic [NUM-1:0][IDW-1:0] map;
		logic [NUM-1:0] synced;
		logic armed;
		logic [MF_TMR_W-1:0] mf_tmr;
		logic [PEND_W-1:0] pend_cur;
		logic [PEND_W-1:0] pend_out;
		logic mis;
		logic rf;
		logic [ST_W-1:0] sts;
		logic [ST_W-1:0] en;
		logic irq;
		logic [CNT_W-1:0] mis_cnt;
		logic [31:0] rdata;
	} state_s;
	state_s q, d;

	logic [NUM-1:0] seen;
	logic [NUM-1:0] mism;
	logic [NUM-1:0][IDW-1:0] lane_id;

	////////////////////////////////////////////////////////////////
	// one tracker per physical lane
	for (genvar p = 0; p < NUM; p++) begin : g_lane
		lane_marker_track #(
			.IDW(IDW)
		) u_trk (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.locked_i(word_boundary_locked_flags_i[p]),
			.mk_valid_i(marker_valid_i[p]),
			.mk_bad_i(marker_bad_i[p]),
			.mk_id_i(marker_id_i[p*IDW +: IDW]),
			.seen_o(seen[p]),
			.id_o(lane_id[p]),
			.mismatch_o(mism[p]),
			.word_err_o(lane_marker_word_error_o[p])
		);
	end

	////////////////////////////////////////////////////////////////
	// apb decode; a read is captured in setup so prdata comes from a flop
	logic acc;
	logic wr;
	logic mapped;
	logic [ST_W-1:0] clr;
	logic [31:0] rd_mux;

	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign mapped = (paddr_i == REG_STATUS) || (paddr_i == REG_CLEAR) ||
		(paddr_i == REG_ENABLE) || (paddr_i == REG_SYNCED) ||
		(paddr_i == REG_LINK) || (paddr_i == REG_MISCNT);
	assign clr = (wr && paddr_i == REG_CLEAR) ? pwdata_i[ST_W-1:0] : '0;

	// read mux; clear register reads back zero
	always_comb begin
		rd_mux = '0;
		case (paddr_i)
			REG_STATUS: rd_mux[ST_W-1:0] = q.sts;
			REG_ENABLE: rd_mux[ST_W-1:0] = q.en;
			REG_SYNCED: rd_mux[NUM-1:0] = q.synced;
			REG_LINK: begin
				rd_mux[LINK_RF] = q.rf;
				rd_mux[LINK_ARMED] = q.armed;
			end
			REG_MISCNT: rd_mux[CNT_W-1:0] = q.mis_cnt;
			default: rd_mux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next state
	logic boundary;
	logic [PEND_W:0] new_err;
	logic [PEND_W:0] sum_cur;
	logic [PEND_W:0] sum_out;
	logic [PEND_W-1:0] drain;
	logic [ST_W-1:0] set;

	always_comb begin
		d = q;
		new_err = '0;
		drain = '0;
		// reverse map: physical lane holding each pcs lane
		d.synced = '0;
		for (int n = 0; n < NUM; n++) begin
			for (int p = 0; p < NUM; p++) begin
				if (seen[p] && word_boundary_locked_flags_i[p] &&
					lane_id[p] == IDW'(n)) begin
					d.map[n] = IDW'(p);
					d.synced[n] = 1'b1;
				end
			end
		end
		// armed once every lane has shown a good marker
		if (word_boundary_locked_flags_i == '0) begin
			d.armed = 1'b0;
		end else if (&seen) begin
			d.armed = 1'b1;
		end
		// wrong markers only count once armed
		for (int p = 0; p < NUM; p++) begin
			if (q.armed && mism[p]) begin
				new_err = new_err + 1'b1;
			end
		end
		// metaframe timer; errors move to the output queue at its end
		boundary = (q.mf_tmr == MF_LAST);
		d.mf_tmr = boundary ? '0 : q.mf_tmr + 1'b1;
		sum_cur = {1'b0, q.pend_cur} + new_err;
		sum_out = {1'b0, q.pend_out};
		if (boundary) begin
			sum_out = sum_out + {1'b0, q.pend_cur};
			sum_cur = new_err;
		end
		// saturate rather than wrap: a storm loses pulses, never invents
		d.pend_cur = sum_cur[PEND_W] ? PEND_MAX : sum_cur[PEND_W-1:0];
		drain = sum_out[PEND_W] ? PEND_MAX : sum_out[PEND_W-1:0];
		d.mis = (drain != '0);
		d.pend_out = d.mis ? drain - 1'b1 : drain;
		d.mis_cnt = q.mis_cnt + CNT_W'(q.mis);
		d.rf = remote_fault_det_i;
		// sticky status: set wins over a clear in the same cycle
		set = '0;
		set[ST_MISALIGN] = q.mis;
		set[ST_MKERR] = |lane_marker_word_error_o;
		set[ST_RFAULT] = remote_fault_det_i & ~q.rf; // rising edge of the condition
		d.sts = (q.sts & ~clr) | set;
		if (wr && paddr_i == REG_ENABLE) begin
			d.en = pwdata_i[ST_W-1:0];
		end
		d.irq = |(d.sts & d.en); // flop keeps the pin glitch free
		if (psel_i && !penable_i) begin
			d.rdata = rd_mux;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.en <= ENABLE_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs from the state register or the tracker flops, except pready_o (constant) and pslverr_o (decoded from the bus)
	assign lane_misalign_pulse_o = q.mis;
	assign remote_fault_o = q.rf;
	assign pcs_lane_phys_map_o = q.map;
	assign pcs_lane_synced_flags_o = q.synced;
	assign irq_o = q.irq;
	assign prdata_o = q.rdata;
	assign pready_o = 1'b1; // zero wait states
	assign pslverr_o = acc & ~mapped;

	////////////////////////////////////////////////////////////////
	property p_never_unarmed;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!q.armed && q.pend_cur == '0 && q.pend_out == '0) |=> !lane_misalign_pulse_o;
	endproperty
	a_never_unarmed: assert property (p_never_unarmed) else $error("pulse while unarmed");

	property p_mf_delay;
		@(posedge clk_i) disable iff (sys_rst_i)
		(q.mf_tmr == MF_LAST && q.pend_cur != '0) |=> lane_misalign_pulse_o;
	endproperty
	a_mf_delay: assert property (p_mf_delay) else $error("no pulse after metaframe");

	property p_back_to_back;
		@(posedge clk_i) disable iff (sys_rst_i)
		(q.pend_out >= 2 || (q.mf_tmr == MF_LAST && q.pend_cur >= 2)) |=>
			lane_misalign_pulse_o [*2];
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("queued errors not pulsed");

	property p_rf_level;
		@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> (remote_fault_o == $past(remote_fault_det_i));
	endproperty
	a_rf_level: assert property (p_rf_level) else $error("remote fault not followed");

	property p_synced_locked;
		@(posedge clk_i) disable iff (sys_rst_i)
		pcs_lane_synced_flags_o[0] |->
			$past(word_boundary_locked_flags_i[d.map[0]]);
	endproperty
	a_synced_locked: assert property (p_synced_locked) else $error("synced without lock");

	property p_set_wins;
		@(posedge clk_i) disable iff (sys_rst_i)
		(|lane_marker_word_error_o && clr[ST_MKERR]) |=> q.sts[ST_MKERR];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("status event lost to clear");

	////////////////////////////////////////////////////////////////
	// lane status, metaframe pacing and bus checks
	property p_werr_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> (lane_marker_word_error_o == $past(marker_valid_i & marker_bad_i));
	endproperty
	a_werr_follow: assert property (p_werr_follow) else $error("word error not one late");

	property p_bad_no_mism;
		@(posedge clk_i) disable iff (sys_rst_i)
		((marker_valid_i & ~marker_bad_i) == '0) |=> (mism == '0);
	endproperty
	a_bad_no_mism: assert property (p_bad_no_mism) else $error("malformed word seen as wrong");

	// a broken arming gate would leak errors into the queue here
	property p_unarmed_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!q.armed && q.pend_cur == '0) |=> (q.pend_cur == '0);
	endproperty
	a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("error kept unarmed");

	property p_pulse_single;
		@(posedge clk_i) disable iff (sys_rst_i)
		(lane_misalign_pulse_o && q.pend_out == '0 && q.mf_tmr != MF_LAST) |=>
			!lane_misalign_pulse_o;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("pulse stretched");

	property p_mf_wrap;
		@(posedge clk_i) disable iff (sys_rst_i)
		(q.mf_tmr == MF_LAST) |=> (q.mf_tmr == '0);
	endproperty
	a_mf_wrap: assert property (p_mf_wrap) else $error("metaframe timer did not wrap");

	property p_synced_any;
		@(posedge clk_i) disable iff (sys_rst_i)
		(pcs_lane_synced_flags_o != '0) |-> $past(word_boundary_locked_flags_i != '0);
	endproperty
	a_synced_any: assert property (p_synced_any) else $error("synced with no lane locked");

	// an unsynced map keeps its last value, observers must gate it
	property p_map_steady;
		@(posedge clk_i) disable iff (sys_rst_i)
		!pcs_lane_synced_flags_o[0] |-> $stable(pcs_lane_phys_map_o[0]);
	endproperty
	a_map_steady: assert property (p_map_steady) else $error("unsynced map moved");

	property p_irq_src;
		@(posedge clk_i) disable iff (sys_rst_i)
		irq_o |-> ((q.sts & q.en) != '0);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("interrupt without enabled status");

	property p_rdata_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		(psel_i && penable_i) |=> $stable(prdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved after access");

	c_misalign: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		lane_misalign_pulse_o ##1 lane_misalign_pulse_o);
	c_armed: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(q.armed));
	c_irq: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(irq_o));
	c_clear_race: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		|lane_marker_word_error_o && clr[ST_MKERR]);
endmodule
`default_nettype wire

//--- inc/pcs_align_pkg.sv
`default_nettype none
package pcs_align_pkg;
	// lane geometry
	localparam int NUM_LANES = 20;
	localparam int LANE_IDW = 5;
	// metaframe length in receive clock cycles (user default, adjustable)
	localparam int MF_CYCLES_DEF = 16384;
	localparam int MF_TMR_W = 16;
	localparam int PEND_W = 8;
	localparam int CNT_W = 16;
	// apb register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CLEAR = 8'h04;
	localparam logic [7:0] REG_ENABLE = 8'h08;
	localparam logic [7:0] REG_SYNCED = 8'h0c;
	localparam logic [7:0] REG_LINK = 8'h10;
	localparam logic [7:0] REG_MISCNT = 8'h14;
	// status / enable bit positions
	localparam int ST_MISALIGN = 0;
	localparam int ST_MKERR = 1;
	localparam int ST_RFAULT = 2;
	localparam int ST_W = 3;
	localparam logic [ST_W-1:0] ENABLE_RST = 3'h0;
	// link register bit positions
	localparam int LINK_RF = 0;
	localparam int LINK_ARMED = 1;
endpackage
`default_nettype wire

//--- hw/lane_marker_track.sv
`timescale 1ns/1ps
`default_nettype none
module lane_marker_track import pcs_align_pkg::*; #(
	parameter int IDW = LANE_IDW
) (
	input wire logic clk_i, // receive clock
	input wire logic sys_rst_i, // sync reset, high
	input wire logic locked_i, // word boundary locked
	input wire logic mk_valid_i, // marker word arrives
	input wire logic mk_bad_i, // marker word malformed
	input wire logic [IDW-1:0] mk_id_i, // pcs lane number in marker
	output logic seen_o, // good marker seen while locked
	output logic [IDW-1:0] id_o, // pcs lane carried here
	output logic mismatch_o, // wrong marker pulse
	output logic word_err_o // malformed marker pulse
);
	typedef struct packed {
		logic seen;
		logic [IDW-1:0] id;
		logic mism;
		logic werr;
	} trk_s;
	trk_s q, d;

	////////////////////////////////////////////////////////////////
	// next state: malformed words never count as wrong markers
	always_comb begin
		d = q;
		d.mism = 1'b0;
		d.werr = mk_valid_i & mk_bad_i;
		if (!locked_i) begin
			d.seen = 1'b0; // losing lock forgets the lane
		end else if (mk_valid_i && !mk_bad_i) begin
			d.mism = q.seen && (mk_id_i != q.id);
			d.seen = 1'b1;
			d.id = mk_id_i; // follow a remapped lane
		end
	end

	// one register stage, all outputs from flops
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign seen_o = q.seen;
	assign id_o = q.id;
	assign mismatch_o = q.mism;
	assign word_err_o = q.werr;

	////////////////////////////////////////////////////////////////
	property p_werr;
		@(posedge clk_i) disable iff (sys_rst_i)
		(mk_valid_i && mk_bad_i) |=> (word_err_o && !mismatch_o);
	endproperty
	a_werr: assert property (p_werr) else $error("malformed marker not flagged");
	property p_mism_seen;
		@(posedge clk_i) disable iff (sys_rst_i)
		mismatch_o |-> ($past(seen_o) && $past(locked_i));
	endproperty
	a_mism_seen: assert property (p_mism_seen) else $error("mismatch without prior marker");
	c_mism: cover property (@(posedge clk_i) disable iff (sys_rst_i) mismatch_o);
endmodule
`default_nettype wire

//--- testbench/lane_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side lane source: boundary lock, marker strobes, remote fault
module lane_partner_model (
	input wire logic clk_i, // receive clock
	output logic [19:0] lock_o, // per lane boundary lock
	output logic [19:0] mk_valid_o, // marker strobe
	output logic [19:0] mk_bad_o, // malformed marker
	output logic [99:0] mk_id_o, // pcs lane ids
	output logic rf_o // remote fault condition
);
	initial begin
		lock_o = 20'h0;
		mk_valid_o = 20'h0;
		mk_bad_o = 20'h0;
		mk_id_o = 100'h0;
		rf_o = 1'b0;
	end
	// one marker cycle; ids go inverted after so stale values never match
	task automatic send(input logic [19:0] m, input logic [99:0] ids, input logic bad);
		@(posedge clk_i);
		mk_valid_o <= m;
		mk_id_o <= ids;
		mk_bad_o <= {20{bad}};
		@(posedge clk_i);
		mk_valid_o <= 20'h0;
		mk_id_o <= ~ids;
		mk_bad_o <= {20{~bad}};
	endtask
	// level inputs change right after an edge
	task automatic set_lvl(input logic [19:0] lk, input logic rf);
		@(posedge clk_i);
		lock_o <= lk;
		rf_o <= rf;
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import pcs_align_pkg::*;;
	localparam int MF = 16;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pulse, rf_lvl, irq, pe;
	logic [19:0] lock, mk_v, mk_b, synced, werr;
	logic [99:0] mk_id, perm, tmp;
	logic [19:0][4:0] map;
	logic prev_p = 1'b0;
	logic rf_lvl_q;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int npulse = 0;
	int nb2b = 0;

	always #20 clk_i = ~clk_i;

	lane_partner_model u_part (.clk_i(clk_i), .lock_o(lock), .mk_valid_o(mk_v),
		.mk_bad_o(mk_b), .mk_id_o(mk_id), .rf_o(rf_lvl));

	pcs_lane_align_status #(.MF_CYCLES(MF)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.word_boundary_locked_flags_i(lock), .marker_valid_i(mk_v), .marker_bad_i(mk_b),
		.marker_id_i(mk_id), .remote_fault_det_i(rf_lvl),
		.lane_misalign_pulse_o(pulse), .remote_fault_o(rf_lvl_q),
		.pcs_lane_phys_map_o(map), .pcs_lane_synced_flags_o(synced),
		.lane_marker_word_error_o(werr), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////////
	// pulse counters and hang guard; ceiling well above the planned sequence
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		npulse <= npulse + int'(pulse === 1'b1);
		nb2b <= nb2b + int'(pulse === 1'b1 && prev_p);
		prev_p <= (pulse === 1'b1);
		if (cyc == 6000) begin
			err_count = err_count + 1;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask

	// apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rd = prdata;
		pe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// wait n edges, then sample settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// physical lane p carries pcs lane (p+3)%20
	initial begin
		for (int p = 0; p < 20; p++) perm[p*5+:5] = 5'((p + 3) % 20);
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wt(1);
		chk("reset pulse", pulse, 0);
		chk("ready", pready, 1);
		apb(1'b0, REG_ENABLE, 32'h0);
		chk("enable rst", rd, 0);
		u_part.set_lvl(20'hfffff, 1'b0);
		// lane 19 silent; lane 0 changes id twice while unarmed
		u_part.send(20'h7ffff, perm, 1'b0);
		tmp = perm;
		tmp[4:0] = 5'h13;
		u_part.send(20'h00001, tmp, 1'b0);
		u_part.send(20'h00001, perm, 1'b0);
		wt(2 * MF + 4);
		chk("unmarked synced", synced[2], 0);
		chk("unarmed pulses", npulse, 0);
		u_part.send(20'hfffff, perm, 1'b0);
		wt(3);
		chk("synced all", synced, 32'hfffff);
		for (int n = 0; n < 20; n++) if (synced[n] === 1'b1) chk("map", map[n], (n + 17) % 20);
		apb(1'b0, REG_LINK, 32'h0);
		chk("armed", rd[LINK_ARMED], 1);
		// lanes 2 and 5 swap ids in one cycle: two errors
		tmp = perm;
		tmp[14:10] = perm[29:25];
		tmp[29:25] = perm[14:10];
		u_part.send(20'h00024, tmp, 1'b0);
		wt(3);
		chk("map swap", map[8], 2);
		wt(2 * MF + 3);
		chk("pulses", npulse, 2);
		chk("back to back", nb2b, 1);
		// clear of the word error bit lands in the cycle its event sets it
		fork
			begin
				u_part.send(20'h00010, perm, 1'b1);
				#1;
				chk("word err", werr, 32'h10);
			end
			apb(1'b1, REG_CLEAR, 32'h2);
		join
		wt(1);
		chk("word err off", werr, 0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("set wins", rd[ST_MKERR], 1);
		wt(2 * MF + 4);
		chk("no pulse on bad word", npulse, 2);
		apb(1'b0, REG_MISCNT, 32'h0);
		chk("miscnt", rd, 2);
		u_part.set_lvl(20'hfffff, 1'b1);
		wt(1);
		chk("rf level", rf_lvl_q, 1);
		apb(1'b1, REG_STATUS, 32'h0);
		apb(1'b1, REG_ENABLE, 32'h7);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", rd, 7);
		wt(1);
		chk("irq on", irq, 1);
		apb(1'b1, REG_ENABLE, 32'h0);
		wt(2);
		chk("irq masked", irq, 0);
		apb(1'b1, REG_ENABLE, 32'h7);
		apb(1'b1, REG_CLEAR, 32'h7);
		wt(2);
		chk("irq cleared", irq, 0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status clr", rd, 0);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", pe, 1);
		chk("unmapped data", rd, 0);
		// losing lock drops every synced flag
		u_part.set_lvl(20'h0, 1'b0);
		wt(3);
		chk("synced lost", synced, 0);
		chk("rf low", rf_lvl_q, 0);
		final_report();
	end
endmodule
`default_nettype wire
